//--- rtl/mpw_pkg.sv
/*
 * shared constants of the host parallel port: word map, field widths,
 * reset values and synchroniser depth.
 * assumes every design file imports the whole package.
 */
`default_nettype none

package mpw_pkg;

   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W       = 7;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned BYTE_W       = 8;
   localparam int unsigned IDX_W        = 6;
   localparam int unsigned BLK_ADDR_W   = 28;
   localparam int unsigned BLK_HIGH_W   = 12;
   localparam int unsigned SYNC_DEPTH   = 2;

   // ----------------------------------------------------------------
   // word offsets
   // ----------------------------------------------------------------
   localparam logic [5:0] OFS_BUS_WIDTH     = 6'h00;
   localparam logic [5:0] OFS_STATUS_LOW    = 6'h02;
   localparam logic [5:0] OFS_STATUS_HIGH   = 6'h03;
   localparam logic [5:0] OFS_ERROR_LOW     = 6'h04;
   localparam logic [5:0] OFS_ERROR_HIGH    = 6'h05;
   localparam logic [5:0] OFS_CFG_BLK_LOW   = 6'h06;
   localparam logic [5:0] OFS_CFG_BLK_HIGH  = 6'h07;
   localparam logic [5:0] OFS_HOST_BLK_LOW  = 6'h08;
   localparam logic [5:0] OFS_HOST_BLK_HIGH = 6'h09;
   localparam logic [5:0] OFS_SECCNT_CMD    = 6'h0a;
   localparam logic [5:0] OFS_REVISION      = 6'h0b;
   localparam logic [5:0] OFS_CONTROL_LOW   = 6'h0c;
   localparam logic [5:0] OFS_CONTROL_HIGH  = 6'h0d;
   localparam logic [5:0] OFS_FILE_TABLE    = 6'h0e;
   localparam logic [5:0] OFS_BUF_FIRST     = 6'h20;
   localparam logic [5:0] OFS_BUF_LAST      = 6'h3f;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned POS_WORD_WIDTH   = 0;
   localparam logic        RST_WORD_WIDTH   = 1'b0;
   localparam logic [27:0] RST_HOST_BLK     = 28'h0000000;
   localparam logic [15:0] RST_SECCNT_CMD   = 16'h0000;
   localparam logic [31:0] RST_CONTROL      = 32'h00000000;
   localparam logic [15:0] RD_RESERVED      = 16'h0000;

endpackage

`default_nettype wire

//--- rtl/mpw_sync.sv
/*
 * multi-bit two-stage synchroniser for host pins.
 * assumes each bit is sampled alone; buses are held stable by the host
 * around its strobes so that a skewed capture settles before use.
 */
`timescale 1ns/1ps
`default_nettype none

module mpw_sync
   import mpw_pkg::*;
#(
   parameter int unsigned WIDTH    = 1,
   parameter logic        RST_VAL  = 1'b0
)
(
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // pins and synchronised copy
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] sync_o
);

   // ----------------------------------------------------------------
   // two flip-flops per bit
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] meta_r;

   initial
   begin
      if (WIDTH == 0 || SYNC_DEPTH != 2)
         $error("mpw_sync: unsupported width or depth");
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_r <= {WIDTH{RST_VAL}};
         sync_o <= {WIDTH{RST_VAL}};
      end
      else
      begin
         meta_r <= pin_i;
         sync_o <= meta_r;
      end
   end

endmodule

`default_nettype wire

//--- rtl/mpw_port.sv
/*
 * host parallel port: strobe decode, byte/word width selection and the
 * word-mode register map of the configuration manager.
 * assumes the host holds address and data stable for at least three
 * clk_i cycles around its strobes; the core side runs on clk_i.
 */
// Overview of operation
// - word mode drives all sixteen data lines, decodes address six to one only.
// - byte mode decodes all seven address lines, uses data lines seven to zero.
// - bus-width bit zero selects width; resets to zero, byte mode.
// - bus-width register stores one bit; other bit positions reserved, read zero.
// - same bus-width bit at byte addresses 0x00, 0x01 and word 0x0.
// - status low half at word 0x02, high half at 0x03, read only.
// - error low half at word 0x04, high half at 0x05, read only.
// - engine block address read only, low 16 at 0x06, upper 12 at 0x07.
// - host block address read-write, low 16 at 0x08, upper 12 at 0x09.
// - sector count and command, 16-bit read-write at word 0x0A.
// - control register 32-bit read-write, low at 0x0C, high at 0x0D.
// - file table information of first partition, read only at word 0x0E.
// - word addresses 0x20 through 0x3F reach the data buffer port.
`timescale 1ns/1ps
`default_nettype none

module mpw_port
   import mpw_pkg::*;
#(
   parameter int unsigned HOST_ADDR_W = ADDR_W,
   parameter int unsigned HOST_DATA_W = DATA_W
)
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  nrst_i,
   // host pins
   input  wire logic [ADDR_W-1:0]     host_address_lines_i,
   input  wire logic [DATA_W-1:0]     host_data_i,
   output logic      [DATA_W-1:0]     host_data_o,
   output logic      [DATA_W-1:0]     host_data_oe_o,
   input  wire logic                  host_sel_n_i,
   input  wire logic                  host_rd_n_i,
   input  wire logic                  host_wr_n_i,
   // core state shown to the host
   input  wire logic [31:0]           status_i,
   input  wire logic [31:0]           error_i,
   input  wire logic [BLK_ADDR_W-1:0] cfg_blk_addr_i,
   input  wire logic [DATA_W-1:0]     revision_i,
   input  wire logic [DATA_W-1:0]     file_table_i,
   // host-written settings
   output logic                       word_width_bit_o,
   output logic [BLK_ADDR_W-1:0]      host_blk_addr_o,
   output logic [DATA_W-1:0]          sector_count_command_o,
   output logic [31:0]                control_o,
   // data buffer port
   input  wire logic [DATA_W-1:0]     buf_rd_data_i,
   output logic                       buf_rd_o,
   output logic [DATA_W-1:0]          buf_wr_data_o,
   output logic                       buf_wr_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   initial
   begin
      if (HOST_ADDR_W != ADDR_W || HOST_DATA_W != DATA_W)
         $error("mpw_port: only a 7-bit address and 16-bit data bus");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic [2:0]        strb_s;
   logic              sel_n_s;
   logic              rd_n_s;
   logic              wr_n_s;

   mpw_sync #(
      .WIDTH   (ADDR_W),
      .RST_VAL (1'b0)
   ) u_sync_addr (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .pin_i   (host_address_lines_i),
      .sync_o  (addr_s)
   );

   mpw_sync #(
      .WIDTH   (DATA_W),
      .RST_VAL (1'b0)
   ) u_sync_data (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .pin_i   (host_data_i),
      .sync_o  (data_s)
   );

   mpw_sync #(
      .WIDTH   (3),
      .RST_VAL (1'b1)
   ) u_sync_strb (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .pin_i   ({host_sel_n_i, host_rd_n_i, host_wr_n_i}),
      .sync_o  (strb_s)
   );

   assign sel_n_s = strb_s[2];
   assign rd_n_s  = strb_s[1];
   assign wr_n_s  = strb_s[0];

   // ----------------------------------------------------------------
   // strobe edges
   // ----------------------------------------------------------------
   logic rd_act_r;
   logic wr_act_r;
   logic rd_act;
   logic wr_act;
   logic wr_evt;
   logic rd_end;

   assign rd_act = !sel_n_s && !rd_n_s;
   assign wr_act = !sel_n_s && !wr_n_s;
   // a write is taken when its strobe ends, with data long settled
   assign wr_evt = wr_act_r && !wr_act;
   assign rd_end = rd_act_r && !rd_act;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rd_act_r <= 1'b0;
         wr_act_r <= 1'b0;
      end
      else
      begin
         rd_act_r <= rd_act;
         wr_act_r <= wr_act;
      end
   end

   // ----------------------------------------------------------------
   // address decode and byte lanes
   // ----------------------------------------------------------------
   logic             word_mode;
   logic [IDX_W-1:0] idx;
   logic             hi_lane;
   logic             be_lo;
   logic             be_hi;
   logic [15:0]      wdata;
   logic             in_buf;

   // word mode ignores address line zero
   assign idx     = addr_s[ADDR_W-1:1];
   assign hi_lane = addr_s[0];
   assign be_lo   = word_mode || !hi_lane;
   assign be_hi   = word_mode || hi_lane;
   assign wdata   = word_mode ? data_s
                              : {data_s[BYTE_W-1:0], data_s[BYTE_W-1:0]};
   assign in_buf  = (idx >= OFS_BUF_FIRST) && (idx <= OFS_BUF_LAST);

   function automatic logic [15:0] merge16(
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic        lo,
      input logic        hi
   );
      merge16 = {hi ? new_v[15:8] : old_v[15:8], lo ? new_v[7:0] : old_v[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // bus width bit
   // ----------------------------------------------------------------
   logic word_width_r;

   assign word_mode        = word_width_r;
   assign word_width_bit_o = word_width_r;

   // either byte lane of word zero reaches the same single bit
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         word_width_r <= RST_WORD_WIDTH;
      else if (wr_evt && idx == OFS_BUS_WIDTH)
         word_width_r <= data_s[POS_WORD_WIDTH];
   end

   // ----------------------------------------------------------------
   // host block address
   // ----------------------------------------------------------------
   logic [15:0]           hblk_hi_w;
   logic [BLK_ADDR_W-1:0] host_blk_r;

   assign host_blk_addr_o = host_blk_r;
   assign hblk_hi_w = merge16({4'h0, host_blk_r[BLK_ADDR_W-1:16]}, wdata, be_lo, be_hi);

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         host_blk_r <= RST_HOST_BLK;
      else if (wr_evt && idx == OFS_HOST_BLK_LOW)
         host_blk_r[15:0] <= merge16(host_blk_r[15:0], wdata, be_lo, be_hi);
      else if (wr_evt && idx == OFS_HOST_BLK_HIGH)
         host_blk_r[BLK_ADDR_W-1:16] <= hblk_hi_w[BLK_HIGH_W-1:0];
   end

   // ----------------------------------------------------------------
   // sector count and command
   // ----------------------------------------------------------------
   logic [15:0] seccnt_r;

   assign sector_count_command_o = seccnt_r;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         seccnt_r <= RST_SECCNT_CMD;
      else if (wr_evt && idx == OFS_SECCNT_CMD)
         seccnt_r <= merge16(seccnt_r, wdata, be_lo, be_hi);
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   logic [31:0] control_r;

   assign control_o = control_r;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         control_r <= RST_CONTROL;
      else if (wr_evt && idx == OFS_CONTROL_LOW)
         control_r[15:0] <= merge16(control_r[15:0], wdata, be_lo, be_hi);
      else if (wr_evt && idx == OFS_CONTROL_HIGH)
         control_r[31:16] <= merge16(control_r[31:16], wdata, be_lo, be_hi);
   end

   // ----------------------------------------------------------------
   // data buffer write
   // ----------------------------------------------------------------
   logic [15:0] buf_wr_data_r;
   logic        buf_wr_r;

   assign buf_wr_data_o = buf_wr_data_r;
   assign buf_wr_o      = buf_wr_r;

   // in byte mode the low byte is held until the high byte completes the word
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         buf_wr_data_r <= 16'h0000;
         buf_wr_r      <= 1'b0;
      end
      else
      begin
         buf_wr_r <= wr_evt && in_buf && be_hi;
         if (wr_evt && in_buf)
            buf_wr_data_r <= merge16(buf_wr_data_r, wdata, be_lo, be_hi);
      end
   end

   // ----------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------
   logic [15:0] rword;
   logic [15:0] rbus;

   always_comb
   begin
      rword = RD_RESERVED;
      if (in_buf)
         rword = buf_rd_data_i;
      else
      begin
         case (idx)
            OFS_BUS_WIDTH:     rword = {15'h0000, word_width_r};
            OFS_STATUS_LOW:    rword = status_i[15:0];
            OFS_STATUS_HIGH:   rword = status_i[31:16];
            OFS_ERROR_LOW:     rword = error_i[15:0];
            OFS_ERROR_HIGH:    rword = error_i[31:16];
            OFS_CFG_BLK_LOW:   rword = cfg_blk_addr_i[15:0];
            OFS_CFG_BLK_HIGH:  rword = {4'h0, cfg_blk_addr_i[27:16]};
            OFS_HOST_BLK_LOW:  rword = host_blk_r[15:0];
            OFS_HOST_BLK_HIGH: rword = {4'h0, host_blk_r[27:16]};
            OFS_SECCNT_CMD:    rword = seccnt_r;
            OFS_REVISION:      rword = revision_i;
            OFS_CONTROL_LOW:   rword = control_r[15:0];
            OFS_CONTROL_HIGH:  rword = control_r[31:16];
            OFS_FILE_TABLE:    rword = file_table_i;
            default:           rword = RD_RESERVED;
         endcase
      end
   end

   // byte mode puts the chosen lane on the low lines; word zero aliases both lanes
   always_comb
   begin
      rbus = rword;
      if (!word_mode)
      begin
         if (hi_lane && idx != OFS_BUS_WIDTH)
            rbus = {8'h00, rword[15:8]};
         else
            rbus = {8'h00, rword[7:0]};
      end
   end

   // ----------------------------------------------------------------
   // read data drive
   // ----------------------------------------------------------------
   logic [15:0] rd_data_r;
   logic        buf_rd_r;

   assign host_data_o    = rd_data_r;
   assign buf_rd_o       = buf_rd_r;
   assign host_data_oe_o = {{8{rd_act_r && word_mode}}, {8{rd_act_r}}};

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rd_data_r <= 16'h0000;
      else if (rd_act)
         rd_data_r <= rbus;
   end

   // the buffer advances once the last byte of a word has been read out
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         buf_rd_r <= 1'b0;
      else
         buf_rd_r <= rd_end && in_buf && be_hi;
   end

endmodule

`default_nettype wire

//--- sim/mpw_port_sva.sv
/*
 * checker of the host port pins: lane enables, read drive, width bit
 * and buffer pulses.
 * assumes it is bound to mpw_port and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module mpw_port_sva
   import mpw_pkg::*;
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // watched ports
   input  wire logic              host_sel_n_i,
   input  wire logic              host_rd_n_i,
   input  wire logic              host_wr_n_i,
   input  wire logic [DATA_W-1:0] host_data_o,
   input  wire logic [DATA_W-1:0] host_data_oe_o,
   input  wire logic              word_width_bit_o,
   input  wire logic              buf_rd_o,
   input  wire logic              buf_wr_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_width_reset: assert property ($rose(nrst_i) |-> !word_width_bit_o)
      else $error("width bit set after reset");
   a_byte_lanes_off: assert property (!word_width_bit_o |-> host_data_oe_o[15:8] == 8'h00)
      else $error("high lanes driven in byte mode");
   a_byte_high_zero: assert property (!word_width_bit_o && host_data_oe_o[0]
      |-> host_data_o[15:8] == 8'h00)
      else $error("high data not zero in byte mode");
   a_word_all_lanes: assert property (word_width_bit_o && host_data_oe_o[0]
      |-> host_data_oe_o == 16'hffff)
      else $error("not all lanes driven in word mode");
   a_read_drive: assert property ((!host_sel_n_i && !host_rd_n_i) [*5]
      |-> host_data_oe_o[0])
      else $error("read strobe not answered");
   a_idle_release: assert property (host_sel_n_i [*5] |-> host_data_oe_o == 16'h0000)
      else $error("data lines driven while idle");
   a_bufrd_pulse: assert property (buf_rd_o |=> !buf_rd_o)
      else $error("buffer read pulse too long");
   a_bufwr_pulse: assert property (buf_wr_o |=> !buf_wr_o)
      else $error("buffer write pulse too long");
   a_width_hold: assert property ((host_sel_n_i || host_wr_n_i) [*8]
      |=> $stable(word_width_bit_o))
      else $error("width bit changed without a write");

   c_word_mode: cover property ($rose(word_width_bit_o));
   c_buf_wr: cover property (buf_wr_o);
   c_buf_rd: cover property (buf_rd_o);
endmodule

`default_nettype wire

//--- sim/mpw_host_bfm.sv
/*
 * host processor model: strobed read and write cycles on the pins.
 * assumes the bench calls wr and rd one at a time; clk_i is the device clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mpw_host_bfm
   import mpw_pkg::*;
(
   // clock
   input  wire logic              clk_i,
   // device side of the data lines
   input  wire logic [DATA_W-1:0] dev_data_i,
   input  wire logic [DATA_W-1:0] dev_oe_i,
   // host pins
   output logic      [ADDR_W-1:0] addr_o,
   output logic      [DATA_W-1:0] wire_o,
   output logic                   sel_n_o,
   output logic                   rd_n_o,
   output logic                   wr_n_o
);
   logic [DATA_W-1:0] drv_r;
   logic              den_r;

   // a released line shows the inverse of the last driven value
   assign wire_o = (dev_oe_i & dev_data_i) | (~dev_oe_i & (den_r ? drv_r : ~drv_r));

   initial
   begin
      addr_o = '0;
      drv_r = '0;
      den_r = 1'b0;
      sel_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
   end

   // strobe held five cycles, address and data five more after it
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      addr_o <= a;
      drv_r <= d;
      den_r <= 1'b1;
      sel_n_o <= 1'b0;
      wr_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      sel_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      den_r <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_i);
      addr_o <= a;
      sel_n_o <= 1'b0;
      rd_n_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      d = wire_o;
      sel_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask
endmodule

`default_nettype wire

//--- sim/mpw_port_tb.sv
/*
 * self-checking bench of the host port: width bit, word map, settings
 * and buffer window in both widths.
 * assumes mpw_pkg, mpw_port, mpw_host_bfm and mpw_port_sva are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module mpw_port_tb
   import mpw_pkg::*;
();
   logic                  clk_i, nrst_i, sel_n, rd_n, wr_n, wwb, buf_rd, buf_wr;
   logic [ADDR_W-1:0]     addr;
   logic [DATA_W-1:0]     hd_i, hd_o, oe, bufd, bw_d, buf_wr_data, rd_d, scc;
   logic [31:0]           core, ctl;
   logic [BLK_ADDR_W-1:0] hba;
   int                    n_fail = 0, compares = 0, n_bw = 0, n_br = 0;
   wire logic [27:0]      cfg = {core[3:0], core[31:8]};

   mpw_port u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .host_address_lines_i(addr),
      .host_data_i(hd_i), .host_data_o(hd_o), .host_data_oe_o(oe), .host_sel_n_i(sel_n),
      .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .status_i(core), .error_i(~core),
      .cfg_blk_addr_i(cfg), .revision_i(~core[31:16]), .file_table_i(core[23:8]),
      .word_width_bit_o(wwb), .host_blk_addr_o(hba), .sector_count_command_o(scc),
      .control_o(ctl), .buf_rd_data_i(bufd), .buf_rd_o(buf_rd),
      .buf_wr_data_o(buf_wr_data), .buf_wr_o(buf_wr));

   mpw_host_bfm u_host (.clk_i(clk_i), .dev_data_i(hd_o), .dev_oe_i(oe), .addr_o(addr),
      .wire_o(hd_i), .sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n));

   // ----------------------------------------------------------------
   // buffer pulse monitor and helpers
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (buf_wr)
      begin
         n_bw <= n_bw + 1;
         bw_d <= buf_wr_data;
      end
      if (buf_rd)
         n_br <= n_br + 1;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   function automatic logic [15:0] ew(input logic [5:0] i);
      case (i)
         6'h00: ew = 16'h0001;
         6'h02: ew = core[15:0];
         6'h03: ew = core[31:16];
         6'h04: ew = ~core[15:0];
         6'h05: ew = ~core[31:16];
         6'h06: ew = cfg[15:0];
         6'h07: ew = {4'h0, cfg[27:16]};
         6'h0b: ew = ~core[31:16];
         6'h0e: ew = core[23:8];
         default: ew = 16'h0000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_width;
      chk("width after reset", 1'b0, wwb);
      chk("control after reset", 32'h0, ctl);
      u_host.rd(7'h01, rd_d);
      chk("width byte read", 8'h00, rd_d[7:0]);
      u_host.wr(7'h01, 16'h00ff);
      chk("width set at byte 1", 1'b1, wwb);
      u_host.rd(7'h00, rd_d);
      chk("width word read", 16'h0001, rd_d);
      u_host.wr(7'h00, 16'hfffe);
      chk("width cleared by word", 1'b0, wwb);
      u_host.wr(7'h00, 16'h0001);
      chk("width set at byte 0", 1'b1, wwb);
   endtask

   task automatic t_map;
      logic [5:0] lst [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                               6'h0b, 6'h0e, 6'h0f, 6'h1f};
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk_i);
         core <= k ? 32'h13579bdf : 32'hfedc0a98;
         for (int j = 0; j < 12; j++)
         begin
            u_host.rd({lst[j], k[0]}, rd_d);
            chk("word map", ew(lst[j]), rd_d);
         end
      end
   endtask

   task automatic t_regs;
      u_host.wr(7'h10, 16'hbeef);
      u_host.wr(7'h12, 16'hffff);
      u_host.wr(7'h15, 16'h5a3c);
      u_host.wr(7'h18, 16'h1357);
      u_host.wr(7'h1a, 16'h9bdf);
      u_host.wr(7'h04, 16'hffff);
      u_host.wr(7'h20, 16'hffff);
      chk("host block addr", 28'hfffbeef, hba);
      chk("sector command", 16'h5a3c, scc);
      chk("control", 32'h9bdf1357, ctl);
      u_host.rd(7'h12, rd_d);
      chk("host block high", 16'h0fff, rd_d);
      u_host.rd(7'h10, rd_d);
      chk("host block low", 16'hbeef, rd_d);
      u_host.rd(7'h14, rd_d);
      chk("sector read", 16'h5a3c, rd_d);
      u_host.rd(7'h19, rd_d);
      chk("control low read", 16'h1357, rd_d);
      u_host.rd(7'h1b, rd_d);
      chk("control high read", 16'h9bdf, rd_d);
      u_host.rd(7'h04, rd_d);
      chk("status after write", core[15:0], rd_d);
      u_host.rd(7'h20, rd_d);
      chk("reserved after write", 16'h0000, rd_d);
   endtask

   task automatic t_buf_word;
      u_host.wr(7'h40, 16'ha1b2);
      chk("buffer writes", 1, n_bw);
      chk("buffer data", 16'ha1b2, bw_d);
      u_host.wr(7'h7e, 16'h0c0d);
      chk("buffer data top", 16'h0c0d, bw_d);
      u_host.rd(7'h7e, rd_d);
      chk("buffer read", bufd, rd_d);
      u_host.rd(7'h3e, rd_d);
      chk("buffer reads", 1, n_br);
   endtask

   task automatic t_buf_byte;
      u_host.wr(7'h00, 16'h0000);
      chk("width cleared", 1'b0, wwb);
      u_host.wr(7'h40, 16'hff77);
      chk("even byte held", 2, n_bw);
      u_host.wr(7'h41, 16'hee66);
      chk("byte pair", 16'h6677, bw_d);
      u_host.rd(7'h7f, rd_d);
      chk("odd byte read", bufd[15:8], rd_d[7:0]);
      chk("byte reads", 2, n_br);
      u_host.wr(7'h14, 16'hff11);
      chk("byte merge", 16'h5a11, scc);
      u_host.rd(7'h05, rd_d);
      chk("status byte", core[15:8], rd_d[7:0]);
   endtask

   // ----------------------------------------------------------------
   // clock, reset and sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   initial
   begin
      nrst_i = 1'b0;
      core = 32'hfedc0a98;
      bufd = 16'h4c3d;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_width;
      t_map;
      t_regs;
      t_buf_word;
      t_buf_byte;
      stop_test;
   end

   initial
   begin
      repeat (50000) @(posedge clk_i);
      n_fail++;
      stop_test;
   end
endmodule

bind mpw_port mpw_port_sva u_sva (.clk_i(clk_i), .nrst_i(nrst_i),
   .host_sel_n_i(host_sel_n_i), .host_rd_n_i(host_rd_n_i), .host_wr_n_i(host_wr_n_i),
   .host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
   .word_width_bit_o(word_width_bit_o), .buf_rd_o(buf_rd_o), .buf_wr_o(buf_wr_o));

`default_nettype wire
